/* hdl/cifm_pkg.sv */
// shared constants, function codes and carrier types of the contact input mapper
package cifm_pkg;

  // contact input count and layout
  localparam int CIFM_NUM_IN    = 10;
  localparam int CIFM_FIRST_OPT = 5;   // inputs from here up exist only with the option fitted
  localparam int CIFM_PAT_LOW   = 5;   // first base of a start-pattern group
  localparam int CIFM_PAT_HIGH  = 8;   // second base, narrow widths only
  localparam int CIFM_PAT_MAXW  = 5;
  localparam int CIFM_SRC_W     = 4;   // width of an input index, 0 means unbound

  // widths of the pattern functions, none for any other function
  localparam logic [2:0] CIFM_W_TWO   = 3'h2;
  localparam logic [2:0] CIFM_W_THREE = 3'h3;
  localparam logic [2:0] CIFM_W_FOUR  = 3'h4;
  localparam logic [2:0] CIFM_W_FIVE  = 3'h5;
  localparam logic [2:0] CIFM_W_NONE  = 3'h0;

  // servo choice n may sit no higher than input n+1
  localparam logic [CIFM_SRC_W-1:0] CIFM_PRE_OFS = 4'h1;

  // pattern number shown when every pattern contact is open
  localparam logic [4:0] CIFM_PAT_ZERO    = 5'h00;
  localparam logic [4:0] CIFM_PAT_DEFAULT = 5'h01;

  // stability time of a contact and its cycle count at the core clock
  localparam int CIFM_CLK_HZ        = 200_000_000;
  localparam int CIFM_FILTER_MS     = 100;
  localparam int CIFM_FILTER_CYCLES = CIFM_CLK_HZ / 1000 * CIFM_FILTER_MS;
  localparam int CIFM_CNT_W         = 25;

  // functions that a contact may carry
  typedef enum logic [3:0] {
    CIFM_F_NONE,
    CIFM_F_RUN_TOGGLE,
    CIFM_F_FORCE_RESET,
    CIFM_F_SUSPEND,
    CIFM_F_SKIP,
    CIFM_F_FIX,
    CIFM_F_OVERRIDE,
    CIFM_F_LOGIC,
    CIFM_F_PAT_TWO,
    CIFM_F_PAT_THREE,
    CIFM_F_PAT_FOUR,
    CIFM_F_PAT_FIVE,
    CIFM_F_PRESET_ONE,
    CIFM_F_PRESET_TWO,
    CIFM_F_PRESET_THREE
  } cifm_func_t;

  typedef cifm_func_t [CIFM_NUM_IN:1] cifm_bind_t;

  // operator requests from the front panel
  typedef struct packed {
    logic force_reset;
    logic suspend;
    logic fix;
    logic manual;
  } cifm_panel_t;

  // actions handed to the sequencing logic
  typedef struct packed {
    logic                   run;
    logic                   force_reset;
    logic                   suspend;
    logic                   skip;
    logic                   fix;
    logic                   manual;
    logic [CIFM_NUM_IN:1]   logic_use;
    logic [2:0]             servo_choice;
    logic                   pat_apply;
    logic [4:0]             pattern_no;
  } cifm_actions_t;

endpackage

/* hdl/cifm_filter.sv */
// synchroniser and stability filter for each contact input
`timescale 1ns/10ps
module cifm_filter
  import cifm_pkg::*;
#(
  parameter int FILTER_CYCLES = CIFM_FILTER_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [CIFM_NUM_IN:1]   raw_in,
  output logic      [CIFM_NUM_IN:1]   raw_sync,
  output logic      [CIFM_NUM_IN:1]   filt
);

  localparam logic [CIFM_CNT_W-1:0] LAST = CIFM_CNT_W'(FILTER_CYCLES - 1);

  genvar i;
  generate
    for (i = 1; i <= CIFM_NUM_IN; i++) begin : g_in
      logic                  meta_q;
      logic                  sync_q;
      logic                  filt_q;
      logic [CIFM_CNT_W-1:0] cnt_q;

      // two flops before anything looks at the pin
      always_ff @(posedge clk) begin
        if (!resetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= raw_in[i];
          sync_q <= meta_q;
        end
      end

      // count restarts whenever the pin agrees with the filtered state again
      always_ff @(posedge clk) begin
        if (!resetn) begin
          cnt_q  <= '0;
          filt_q <= 1'b0;
        end else if (sync_q == filt_q) begin
          cnt_q <= '0;
        end else if (cnt_q == LAST) begin
          cnt_q  <= '0;
          filt_q <= sync_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end

      assign raw_sync[i] = sync_q;
      assign filt[i]     = filt_q;
    end
  endgenerate

endmodule

/* hdl/cifm_mapper.sv */
// contact input to control function mapper, top level
`timescale 1ns/10ps
// How it works
// - contact input 1 always carries the run/reset toggle
// - inputs 2 to 10 take a chosen function; 5 to 10 need the option
// - two- and three-wide pattern selection only on input 5 or 8
// - four- and five-wide pattern selection only on input 5
// - level functions follow the filtered input exactly
// - edge functions toggle on each off-to-on transition
// - run/reset is edge driven, on means run, never blocked
// - step forward is edge driven and blocked while suspended
// - reset, suspend, fix, override, logic, pattern and servo choice are level
// - two-wide picks 3 patterns, three-wide 7; none while fix active
// - external pattern applied only if bound and outside enable on
// - servo choice n lives on inputs 2..n+1; blocked in manual or reset
// - an action is suppressed while its blocking condition holds
// - a change counts only after 0.1 s of stable level
// - a bound function ignores the front-panel request for it
// - duplicate function other than logic use: lowest input wins, higher ones invalid
// - patterns on both 5 and 8: input 8 loses
// - a pattern group wipes functions on the inputs it consumes
// - unbinding keeps a running action, except logic use and external pattern apply, which stop
// - five-wide reads inputs 5 to 9 binary, input 5 least significant
// - pattern number zero is replaced by one
// - raw state of every fitted input is reported
module cifm_mapper
  import cifm_pkg::*;
#(
  parameter int FILTER_CYCLES = CIFM_FILTER_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [CIFM_NUM_IN:1]   contact_input,
  input  wire logic                   option_fitted,
  input  wire logic                   outside_pattern_enable,
  input  wire cifm_bind_t             bind_cfg,
  input  wire cifm_panel_t            panel_req,
  output cifm_actions_t               actions_q,
  output logic [CIFM_NUM_IN:1]        bind_valid_q,
  output logic [CIFM_NUM_IN:1]        raw_mon_q
);

  localparam int NLEV = 7;   // level functions with a held state

  // width of a pattern function, zero for anything else
  function automatic logic [2:0] pat_width(input cifm_func_t f);
    case (f)
      CIFM_F_PAT_TWO:   pat_width = CIFM_W_TWO;
      CIFM_F_PAT_THREE: pat_width = CIFM_W_THREE;
      CIFM_F_PAT_FOUR:  pat_width = CIFM_W_FOUR;
      CIFM_F_PAT_FIVE:  pat_width = CIFM_W_FIVE;
      default:          pat_width = CIFM_W_NONE;
    endcase
  endfunction

  // lowest input carrying a function, zero if none
  function automatic logic [CIFM_SRC_W-1:0] find_src(input cifm_bind_t b, input cifm_func_t f);
    find_src = '0;
    for (int k = CIFM_NUM_IN; k >= 1; k--) begin
      if (b[k] == f) begin
        find_src = CIFM_SRC_W'(k);
      end
    end
  endfunction

  logic [CIFM_NUM_IN:1] raw_sync;
  logic [CIFM_NUM_IN:1] filt;
  logic [CIFM_NUM_IN:1] filt_prev_q;

  cifm_filter #(
    .FILTER_CYCLES (FILTER_CYCLES)
  ) u_filter (
    .clk      (clk),
    .resetn   (resetn),
    .raw_in   (contact_input),
    .raw_sync (raw_sync),
    .filt     (filt)
  );

  // resolution of the configured bindings into the effective ones
  cifm_bind_t           fitted_b;
  cifm_bind_t           legal_b;
  cifm_bind_t           eff_b;
  logic [CIFM_NUM_IN:1] consumed;
  logic [2:0]           w_low;
  logic [2:0]           w_high;
  logic [2:0]           pat_w;
  logic [CIFM_SRC_W-1:0] pat_base;
  logic                 use_high;

  always_comb begin
    fitted_b    = bind_cfg;
    fitted_b[1] = CIFM_F_RUN_TOGGLE;
    for (int k = CIFM_FIRST_OPT; k <= CIFM_NUM_IN; k++) begin
      if (!option_fitted) begin
        fitted_b[k] = CIFM_F_NONE;
      end
    end
    for (int k = 2; k < CIFM_FIRST_OPT; k++) begin
      if (fitted_b[k] == CIFM_F_RUN_TOGGLE) begin
        fitted_b[k] = CIFM_F_NONE;
      end
    end
    w_low  = pat_width(fitted_b[CIFM_PAT_LOW]);
    w_high = pat_width(fitted_b[CIFM_PAT_HIGH]);
    // input 8 may carry only narrow widths and loses to input 5
    use_high = (w_low == CIFM_W_NONE) &&
               ((w_high == CIFM_W_TWO) || (w_high == CIFM_W_THREE));
    pat_w    = use_high ? w_high : w_low;
    pat_base = use_high ? CIFM_SRC_W'(CIFM_PAT_HIGH) : CIFM_SRC_W'(CIFM_PAT_LOW);
    consumed = '0;
    for (int k = 1; k <= CIFM_NUM_IN; k++) begin
      if ((pat_w != CIFM_W_NONE) && (k > int'(pat_base)) &&
          (k < int'(pat_base) + int'(pat_w))) begin
        consumed[k] = 1'b1;
      end
    end
    legal_b = fitted_b;
    for (int k = 2; k <= CIFM_NUM_IN; k++) begin
      if (consumed[k]) begin
        legal_b[k] = CIFM_F_NONE;
      end else if ((pat_width(fitted_b[k]) != CIFM_W_NONE) &&
                   !((pat_w != CIFM_W_NONE) && (k == int'(pat_base)))) begin
        legal_b[k] = CIFM_F_NONE;
      end
      case (fitted_b[k])
        CIFM_F_PRESET_ONE: begin
          if (k > 1 + int'(CIFM_PRE_OFS)) legal_b[k] = CIFM_F_NONE;
        end
        CIFM_F_PRESET_TWO: begin
          if (k > 2 + int'(CIFM_PRE_OFS)) legal_b[k] = CIFM_F_NONE;
        end
        CIFM_F_PRESET_THREE: begin
          if (k > 3 + int'(CIFM_PRE_OFS)) legal_b[k] = CIFM_F_NONE;
        end
        default: begin
        end
      endcase
    end
    // duplicates: a later copy of a function is dropped; logic use may repeat
    eff_b = legal_b;
    for (int k = 2; k <= CIFM_NUM_IN; k++) begin
      for (int j = 1; j < k; j++) begin
        if ((legal_b[j] == legal_b[k]) && (legal_b[k] != CIFM_F_LOGIC)) begin
          eff_b[k] = CIFM_F_NONE;
        end
      end
    end
  end

  // binding validity and raw monitor, unfitted inputs read as zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bind_valid_q <= '0;
      raw_mon_q    <= '0;
      filt_prev_q  <= '0;
    end else begin
      filt_prev_q <= filt;
      for (int k = 1; k <= CIFM_NUM_IN; k++) begin
        bind_valid_q[k] <= (eff_b[k] != CIFM_F_NONE);
        raw_mon_q[k]    <= raw_sync[k] && (option_fitted || (k < CIFM_FIRST_OPT));
      end
    end
  end

  // run/reset toggle from input 1, nothing blocks it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      actions_q.run <= 1'b0;
    end else if (filt[1] && !filt_prev_q[1]) begin
      actions_q.run <= !actions_q.run;
    end
  end

  // step forward: toggles on each rising edge while not suspended
  logic [CIFM_SRC_W-1:0] skip_src;
  assign skip_src = find_src(eff_b, CIFM_F_SKIP);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      actions_q.skip <= 1'b0;
    end else if ((skip_src != '0) && filt[skip_src] && !filt_prev_q[skip_src] &&
                 !actions_q.suspend) begin
      actions_q.skip <= !actions_q.skip;
    end
  end

  // held level functions; an unbound one keeps its state until the panel takes over
  localparam cifm_func_t LEV_F [NLEV] = '{CIFM_F_FORCE_RESET, CIFM_F_SUSPEND, CIFM_F_FIX,
                                          CIFM_F_OVERRIDE, CIFM_F_PRESET_ONE,
                                          CIFM_F_PRESET_TWO, CIFM_F_PRESET_THREE};
  logic [NLEV-1:0] lev_panel;
  logic [NLEV-1:0] lev_st;
  assign lev_panel = {3'h0, panel_req.manual, panel_req.fix, panel_req.suspend,
                      panel_req.force_reset};

  genvar g;
  generate
    for (g = 0; g < NLEV; g++) begin : g_lev
      logic [CIFM_SRC_W-1:0] src;
      logic                  st_q;
      logic                  held_q;
      assign src = find_src(eff_b, LEV_F[g]);

      always_ff @(posedge clk) begin
        if (!resetn) begin
          st_q   <= 1'b0;
          held_q <= 1'b0;
        end else if (src != '0) begin
          st_q   <= filt[src];
          held_q <= filt[src];
        end else if (held_q) begin
          held_q <= !lev_panel[g];
          st_q   <= 1'b1;
        end else begin
          st_q <= lev_panel[g];
        end
      end
      assign lev_st[g] = st_q;
    end
  endgenerate

  // blocking: servo choices idle in manual or reset state
  logic reset_state;
  logic preset_block;
  assign reset_state  = lev_st[0] || !actions_q.run;
  assign preset_block = lev_st[3] || reset_state;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      actions_q.force_reset  <= 1'b0;
      actions_q.suspend      <= 1'b0;
      actions_q.fix          <= 1'b0;
      actions_q.manual       <= 1'b0;
      actions_q.servo_choice <= '0;
    end else begin
      actions_q.force_reset  <= lev_st[0];
      actions_q.suspend      <= lev_st[1];
      actions_q.fix          <= lev_st[2];
      actions_q.manual       <= lev_st[3];
      actions_q.servo_choice <= preset_block ? 3'h0 : lev_st[6:4];
    end
  end

  // logic use marker stops as soon as its binding goes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      actions_q.logic_use <= '0;
    end else begin
      for (int k = 1; k <= CIFM_NUM_IN; k++) begin
        actions_q.logic_use[k] <= (eff_b[k] == CIFM_F_LOGIC) && filt[k];
      end
    end
  end

  // start pattern number from the bound group, binary, lowest input first
  logic [4:0] pat_raw;
  always_comb begin
    pat_raw = '0;
    for (int b = 0; b < CIFM_PAT_MAXW; b++) begin
      if ((b < int'(pat_w)) && (int'(pat_base) + b <= CIFM_NUM_IN)) begin
        pat_raw[b] = filt[int'(pat_base) + b];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      actions_q.pat_apply  <= 1'b0;
      actions_q.pattern_no <= CIFM_PAT_DEFAULT;
    end else begin
      actions_q.pat_apply <= (pat_w != CIFM_W_NONE) && outside_pattern_enable &&
                             !lev_st[2];
      if ((pat_w != CIFM_W_NONE) && !lev_st[2]) begin
        actions_q.pattern_no <= (pat_raw == CIFM_PAT_ZERO) ? CIFM_PAT_DEFAULT : pat_raw;
      end
    end
  end

endmodule

/* dv/cifm_contacts.sv */
// behavioural dry contacts on the mapper pins
`timescale 1ns/10ps
module cifm_contacts (
  input  wire logic        clk,
  output logic      [10:1] contact_input
);
  initial contact_input = 10'h000;
  // set a level, then hold it past the stability time
  task automatic put(input logic [10:1] v, input int hold);
    @(posedge clk) contact_input <= v;
    repeat (hold) @(posedge clk);
  endtask
  // short bounce, the kind a worn contact makes
  task automatic bounce(input int k, input int len);
    @(posedge clk) contact_input[k] <= ~contact_input[k];
    repeat (len) @(posedge clk);
    contact_input[k] <= ~contact_input[k];
  endtask
endmodule

/* dv/cifm_mapper_sva.sv */
// assertions on the contact mapper ports
`timescale 1ns/10ps
module cifm_mapper_sva
  import cifm_pkg::*;
#(
  parameter int FILTER_CYCLES = CIFM_FILTER_CYCLES
) (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic [CIFM_NUM_IN:1] contact_input,
  input wire logic                 option_fitted,
  input wire logic                 outside_pattern_enable,
  input wire cifm_bind_t           bind_cfg,
  input wire cifm_actions_t        actions_q,
  input wire logic [CIFM_NUM_IN:1] bind_valid_q,
  input wire logic [CIFM_NUM_IN:1] raw_mon_q
);
  logic [2:0] up_q;
  // edges since release; lagged checks wait until the synchroniser is flushed
  always_ff @(posedge clk) begin
    if (!resetn) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  run_fixed_a: assert property (up_q != 3'h0 |-> bind_valid_q[1])
    else $error("input one lost its binding");
  mon_lag_a: assert property (up_q == 3'h7 |->
    raw_mon_q[4:1] == $past(contact_input[4:1], 3))
    else $error("monitor does not follow the pins");
  unfit_zero_a: assert property (up_q != 3'h0 && !$past(option_fitted) |->
    raw_mon_q[10:5] == 6'h00 && bind_valid_q[10:5] == 6'h00)
    else $error("absent inputs are active");
  pat_eight_a: assert property ($past(bind_cfg[8]) inside {CIFM_F_PAT_FOUR,
    CIFM_F_PAT_FIVE} |-> !bind_valid_q[8])
    else $error("wide pattern accepted on input eight");
  pat_place_a: assert property ($past(bind_cfg[3]) inside {[CIFM_F_PAT_TWO:
    CIFM_F_PAT_FIVE]} |-> !bind_valid_q[3])
    else $error("pattern accepted on input three");
  preset_place_a: assert property ($past(bind_cfg[5]) inside {[CIFM_F_PRESET_ONE:
    CIFM_F_PRESET_THREE]} |-> !bind_valid_q[5])
    else $error("servo choice accepted on input five");
  skip_hold_a: assert property ($past(actions_q.suspend) |->
    $stable(actions_q.skip))
    else $error("step forward moved while suspended");
  pat_enable_a: assert property (actions_q.pat_apply |->
    $past(outside_pattern_enable))
    else $error("pattern applied without enable");
  fix_freeze_a: assert property (actions_q.fix && $past(actions_q.fix) |->
    !actions_q.pat_apply && $stable(actions_q.pattern_no))
    else $error("pattern acted during fix");
  pat_nonzero_a: assert property (actions_q.pattern_no != CIFM_PAT_ZERO)
    else $error("pattern number zero shown");
  cover property (actions_q.pat_apply);
  cover property ($rose(actions_q.run));
  cover property ($past(actions_q.suspend) && contact_input[3]);
endmodule
bind cifm_mapper cifm_mapper_sva #(.FILTER_CYCLES(FILTER_CYCLES)) cifm_mapper_sva_inst (
  .clk, .resetn, .contact_input, .option_fitted, .outside_pattern_enable,
  .bind_cfg, .actions_q, .bind_valid_q, .raw_mon_q);

/* dv/test_cifm_mapper.sv */
// self-checking bench of the contact mapper
`timescale 1ns/10ps
module test_cifm_mapper;
  import cifm_pkg::*;
  localparam int FC = 8;
  localparam int W  = FC + 8;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  logic          option_fitted = 1'b1;
  logic          outside_pattern_enable = 1'b0;
  cifm_bind_t    bind_cfg;
  cifm_panel_t   panel_req = 4'h0;
  logic [10:1]   contact_input;
  cifm_actions_t actions_q;
  logic [10:1]   bind_valid_q;
  logic [10:1]   raw_mon_q;
  int            error_cnt = 0;
  int            checks = 0;
  int            v;
  int            p;
  logic [10:1]   ci;
  always #2.5 clk = ~clk;
  cifm_contacts cifm_contacts_inst (.clk(clk), .contact_input(contact_input));
  cifm_mapper #(.FILTER_CYCLES(FC)) cifm_mapper_inst (
    .clk(clk), .resetn(resetn), .contact_input(contact_input),
    .option_fitted(option_fitted), .outside_pattern_enable(outside_pattern_enable),
    .bind_cfg(bind_cfg), .panel_req(panel_req), .actions_q(actions_q),
    .bind_valid_q(bind_valid_q), .raw_mon_q(raw_mon_q));
  // compare helpers, one per result width
  task automatic cmp_bits(input logic [10:1] g, input logic [10:1] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t bits %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_num(input logic [4:0] g, input logic [4:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t number %0d want %0d", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    cmp_num({4'h0, g}, {4'h0, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // pattern width of a code, 0 for other functions
  function automatic int pw(cifm_func_t f);
    return (f >= CIFM_F_PAT_TWO && f <= CIFM_F_PAT_FIVE) ? int'(f) - 6 : 0;
  endfunction
  // model of binding resolution: place, option, groups, then duplicates
  function automatic logic [10:1] exp_valid(cifm_bind_t b, logic fit);
    logic [10:1] ok;
    ok = 10'h001;
    for (int k = 2; k <= 10; k++) begin
      ok[k] = b[k] != CIFM_F_NONE && b[k] != CIFM_F_RUN_TOGGLE && (fit || k < 5);
      if (pw(b[k]) > 0) ok[k] = ok[k] && (k == 5 || (k == 8 && pw(b[k]) < 4));
      if (b[k] >= CIFM_F_PRESET_ONE) ok[k] = ok[k] && (k <= int'(b[k]) - 10);
    end
    if (ok[5] && pw(b[5]) > 0) begin
      for (int k = 6; k < 5 + pw(b[5]); k++) ok[k] = 1'b0;
      if (pw(b[8]) > 0) ok[8] = 1'b0;
    end
    if (ok[8] && pw(b[8]) > 0) for (int k = 9; k < 8 + pw(b[8]); k++) ok[k] = 1'b0;
    for (int k = 3; k <= 10; k++)
      for (int j = 2; j < k; j++)
        if (ok[j] && b[j] == b[k] && b[k] != CIFM_F_LOGIC) ok[k] = 1'b0;
    return ok;
  endfunction
  // contact change held past the filter, then let outputs settle
  task automatic go(input logic [10:1] c);
    cifm_contacts_inst.put(c, W);
    #1;
  endtask
  initial begin
    for (int k = 1; k <= 10; k++) bind_cfg[k] = CIFM_F_NONE;
    void'($urandom(78014));
    repeat (10) @(posedge clk);
    cmp_num(actions_q.pattern_no, CIFM_PAT_DEFAULT);
    resetn <= 1'b1;
    // random binding tables against the resolution model
    repeat (60) begin
      @(posedge clk);
      for (int k = 2; k <= 10; k++) bind_cfg[k] <= cifm_func_t'($urandom_range(14));
      option_fitted <= 1'($urandom_range(1));
      @(posedge clk);
      #1;
      cmp_bits(bind_valid_q, exp_valid(bind_cfg, option_fitted));
    end
    @(posedge clk);
    for (int k = 2; k <= 10; k++) bind_cfg[k] <= CIFM_F_NONE;
    bind_cfg[2] <= CIFM_F_SUSPEND;
    bind_cfg[3] <= CIFM_F_SKIP;
    bind_cfg[4] <= CIFM_F_FIX;
    bind_cfg[5] <= CIFM_F_PAT_FIVE;
    bind_cfg[10] <= CIFM_F_LOGIC;
    option_fitted <= 1'b1;
    outside_pattern_enable <= 1'b1;
    go(10'h000);
    // level suspend, panel request ignored while bound
    go(10'h002);
    cmp_flag(actions_q.suspend, 1'b1);
    panel_req.suspend <= 1'b1;
    go(10'h000);
    cmp_flag(actions_q.suspend, 1'b0);
    panel_req.suspend <= 1'b0;
    // run toggles on each closing, holds when open, ignores a bounce
    go(10'h001);
    go(10'h000);
    cmp_flag(actions_q.run, 1'b1);
    go(10'h001);
    go(10'h000);
    cmp_flag(actions_q.run, 1'b0);
    cifm_contacts_inst.bounce(1, FC - 3);
    go(10'h000);
    cmp_flag(actions_q.run, 1'b0);
    // step forward toggles, but not while suspended
    go(10'h004);
    go(10'h000);
    cmp_flag(actions_q.skip, 1'b1);
    go(10'h002);
    go(10'h006);
    go(10'h002);
    cmp_flag(actions_q.skip, 1'b1);
    go(10'h000);
    // five-wide pattern, input 5 least significant, zero reads one
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 0 : $urandom_range(31);
      p = (v == 0) ? 1 : v;
      go(10'(v) << 4);
      cmp_num(actions_q.pattern_no, 5'(p));
      cmp_flag(actions_q.pat_apply, 1'b1);
    end
    // fix first, alone: pattern contacts moving with it would still count
    go((10'(v) << 4) | 10'h008);
    cmp_flag(actions_q.fix, 1'b1);
    go(10'h1F8);
    cmp_num(actions_q.pattern_no, 5'(p));
    cmp_flag(actions_q.pat_apply, 1'b0);
    outside_pattern_enable <= 1'b0;
    go(10'h010);
    cmp_flag(actions_q.pat_apply, 1'b0);
    // two-wide pattern on input 8
    bind_cfg[5] <= CIFM_F_NONE;
    bind_cfg[8] <= CIFM_F_PAT_TWO;
    for (int i = 0; i < 4; i++) begin
      go(10'(i) << 7);
      cmp_num(actions_q.pattern_no, 5'((i == 0) ? 1 : i));
    end
    // unbinding while on: logic use stops, suspend carries on
    go(10'h202);
    cmp_bits(actions_q.logic_use, 10'h200);
    bind_cfg[2] <= CIFM_F_NONE;
    bind_cfg[10] <= CIFM_F_NONE;
    repeat (3) @(posedge clk);
    #1;
    cmp_bits(actions_q.logic_use, 10'h000);
    cmp_flag(actions_q.suspend, 1'b1);
    // servo choice one on input 2: idle while in reset state, live once running
    bind_cfg[2] <= CIFM_F_PRESET_ONE;
    go(10'h002);
    cmp_num({2'h0, actions_q.servo_choice}, 5'h00);
    go(10'h003);
    go(10'h002);
    cmp_flag(actions_q.run, 1'b1);
    cmp_num({2'h0, actions_q.servo_choice}, 5'h01);
    cmp_flag(actions_q.manual, 1'b0);
    // monitor shows raw state of fitted inputs only
    option_fitted <= 1'b0;
    go(10'h3FE);
    cmp_bits(raw_mon_q, 10'h00E);
    option_fitted <= 1'b1;
    go(10'h3FE);
    cmp_bits(raw_mon_q, 10'h3FE);
    report_and_stop();
  end
  // hang guard, well beyond the expected run length
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
